// [logic/acr_pkg.sv]
/*
 * acr_pkg: register map, field positions, reset values and pattern codes
 * for the converter control register bank.
 * assumes: 8-bit register address and data on the serial port side.
 */
package acr_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05; // channel select for local regs
   localparam logic [7:0] ADDR_POWER_MODE = 8'h08; // power_mode_control (local)
   localparam logic [7:0] ADDR_CLK_COND   = 8'h09; // clock_conditioning (global)
   localparam logic [7:0] ADDR_CLK_DIV    = 8'h0b; // input_clock_divider (global)
   localparam logic [7:0] ADDR_TEST_PAT   = 8'h0d; // output_test_pattern (local)
   localparam logic [7:0] ADDR_SELFTEST   = 8'h0e; // selftest_control (global)
   localparam logic [7:0] ADDR_INPUT_BIAS = 8'h0f; // input_bias_control (global)
   localparam logic [7:0] ADDR_OFFSET     = 8'h10; // conversion_offset_trim (local)
   localparam logic [7:0] ADDR_COMMIT     = 8'hff; // shadow_commit
   // reset values
   localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
   localparam logic [7:0] RST_POWER_MODE = 8'h80;
   localparam logic [7:0] RST_CLK_COND   = 8'h01;
   localparam logic [7:0] RST_CLK_DIV    = 8'h00;
   localparam logic [7:0] RST_TEST_PAT   = 8'h00;
   localparam logic [7:0] RST_SELFTEST   = 8'h04;
   localparam logic [7:0] RST_INPUT_BIAS = 8'h00;
   localparam logic [7:0] RST_OFFSET     = 8'h00;
   // writable bits per register; bit 7 of power mode is a fixed one
   localparam logic [7:0] MSK_CHAN_INDEX = 8'h03;
   localparam logic [7:0] MSK_POWER_MODE = 8'h23;
   localparam logic [7:0] FIX_POWER_MODE = 8'h80;
   localparam logic [7:0] MSK_CLK_COND   = 8'h01;
   localparam logic [7:0] MSK_CLK_DIV    = 8'h07;
   localparam logic [7:0] MSK_TEST_PAT   = 8'h37;
   localparam logic [7:0] MSK_SELFTEST   = 8'h05;
   localparam logic [7:0] MSK_INPUT_BIAS = 8'h01;
   localparam logic [7:0] MSK_COMMIT     = 8'h01;
   // field positions
   localparam int POS_COMMIT     = 0;
   localparam int POS_EXT_PD_FN  = 5;
   localparam int POS_DCS_EN     = 0;
   localparam int POS_BUILTIN_SELFTEST_EN    = 0;
   localparam int POS_BUILTIN_SELFTEST_RST   = 2;
   localparam int POS_SERVO_EN   = 0;
   localparam int POS_LONG_RST   = 5;
   localparam int POS_SHORT_RST  = 4;
   // internal power field codes
   localparam logic [1:0] PWR_FULL_DOWN = 2'h1;
   localparam logic [1:0] PWR_STANDBY   = 2'h2;
   // test pattern codes, field bits 2:0
   typedef enum logic [2:0] {
      TP_OFF      = 3'b000,
      TP_MIDSCALE = 3'b001,
      TP_POS_FS   = 3'b010,
      TP_NEG_FS   = 3'b011,
      TP_CHECKER  = 3'b100,
      TP_LONG_PN  = 3'b101,
      TP_SHORT_PN = 3'b110,
      TP_TOGGLE   = 3'b111
   } acr_pattern_t;
endpackage

// [logic/acr_regbank.sv]
/*
 * acr_regbank: shadowed control registers of a dual-channel converter,
 * their active copies, the decoded controls and the output data path
 * (offset trim, test patterns, pseudo-random generators).
 * assumes: a serial port engine outside turns frames into one-cycle
 * read/write strobes with address and data; samples arrive with a strobe.
 */
// Behaviour
// - commit bit copies all shadows to active
// - power field: 01 down, 10 standby, else normal
// - pin function bit: 0 power-down, 1 standby
// - stabilizer enable bit 0, set at reset
// - clock divided by ratio code plus one
// - nonzero divide ratio forces stabilizer on
// - selected test pattern replaces converted samples
// - pattern codes decode in documented order
// - per-channel resets hold long, short generators
// - self-test enable bit 0, sequence reset bit 2
// - common-mode servo enable bit 0, off at reset
// - signed eight-bit offset added per channel
// - shadow writes act only after commit
// - commit bit clears itself after update
// - channel index steers local writes, reads favour A
`timescale 1ns/100ps
module acr_regbank #(
   parameter int SMP_W = 14 // converter sample width
) (
   input  wire logic                   core_clk,     // register and sample clock
   input  wire logic                   srst,         // synchronous reset, high
   input  wire logic                   cfg_wr,       // write strobe from serial port
   input  wire logic                   cfg_rd,       // read strobe from serial port
   input  wire logic [7:0]             cfg_addr,     // register address
   input  wire logic [7:0]             cfg_wdata,    // write data
   output logic      [7:0]             cfg_rdata,    // read data, one cycle later
   output logic                        cfg_rvalid,   // read data valid pulse
   input  wire logic                   pdwn_pin,     // external power pin level
   input  wire logic                   smp_strobe,   // new sample on both channels
   input  wire logic [1:0][SMP_W-1:0]  smp_in,       // twos complement samples
   output logic      [1:0][SMP_W-1:0]  smp_out,      // trimmed or test data
   output logic                        smp_out_vld,  // output data valid pulse
   output logic      [1:0]             full_pd,      // channel in full power-down
   output logic      [1:0]             standby,      // channel in standby
   output logic                        dcs_active,   // duty-cycle stabilizer on
   output logic      [2:0]             div_ratio,    // divide by ratio plus one
   output logic                        builtin_selftest_en,      // built-in self-test enable
   output logic                        builtin_selftest_seq_rst, // self-test sequence reset
   output logic                        cm_servo_en   // input common-mode servo
);
   import acr_pkg::*;

   localparam int LONG_W  = 23; // long generator length
   localparam int SHORT_W = 9;  // short generator length
   localparam logic [SMP_W-1:0] POS_FS = {1'b0, {(SMP_W-1){1'b1}}}; // largest code
   localparam logic [SMP_W-1:0] NEG_FS = {1'b1, {(SMP_W-1){1'b0}}}; // smallest code
   localparam logic [SMP_W-1:0] CHECK  = SMP_W'({(SMP_W+1)/2{2'b01}}); // 0101.. word

   // one settings set, used for both shadow and active copies
   typedef struct packed {
      logic [1:0][7:0] pwr;   // per-channel power mode
      logic [1:0][7:0] tpat;  // per-channel test pattern
      logic [1:0][7:0] offs;  // per-channel offset trim
      logic [7:0]      clk;   // clock conditioning
      logic [7:0]      div;   // clock divider
      logic [7:0]      builtin_selftest;  // self-test control
      logic [7:0]      inp;   // input bias control
   } acr_cfg_t;

   // whole block state
   typedef struct packed {
      acr_cfg_t                   shd;    // shadow copy, written by host
      acr_cfg_t                   act;    // active copy, steers hardware
      logic [7:0]                 chsel;  // channel index
      logic                       commit; // pending transfer
      logic [1:0][LONG_W-1:0]     lgen;   // long generators
      logic [1:0][SHORT_W-1:0]    sgen;   // short generators
      logic                       phase;  // alternating word phase
      logic [1:0][SMP_W-1:0]      dout;   // output data
      logic                       dvld;   // output valid
      logic [7:0]                 rdata;  // read data
      logic                       rvld;   // read valid
   } acr_state_t;

   acr_state_t st_q; // registered state
   acr_state_t st_d; // next state

   // reset image of the settings
   function automatic acr_cfg_t cfg_reset();
      acr_cfg_t c;
      c.pwr  = {RST_POWER_MODE, RST_POWER_MODE};
      c.tpat = {RST_TEST_PAT, RST_TEST_PAT};
      c.offs = {RST_OFFSET, RST_OFFSET};
      c.clk  = RST_CLK_COND;
      c.div  = RST_CLK_DIV;
      c.builtin_selftest = RST_SELFTEST;
      c.inp  = RST_INPUT_BIAS;
      return c;
   endfunction

   // saturating add of an eight-bit signed trim to a sample
   function automatic logic [SMP_W-1:0] trim(input logic [SMP_W-1:0] s,
                                             input logic [7:0] o);
      logic [SMP_W:0] sum;
      sum = {s[SMP_W-1], s} + {{(SMP_W-7){o[7]}}, o};
      if (sum[SMP_W] != sum[SMP_W-1]) begin // overflow: clamp
         trim = sum[SMP_W] ? NEG_FS : POS_FS;
      end else begin
         trim = sum[SMP_W-1:0];
      end
   endfunction

   // next-state logic
   always_comb begin
      logic [SMP_W-1:0] pat;  // pattern word for one channel
      logic             rd_b; // read from channel B
      logic [7:0]       rv;   // read value
      pat  = '0;
      rd_b = 1'b0;
      rv   = 8'h00;
      st_d = st_q;
      st_d.dvld = 1'b0;
      st_d.rvld = 1'b0;

      // transfer shadow to active in one step, then drop the bit
      if (st_q.commit) begin
         st_d.act    = st_q.shd;
         st_d.commit = 1'b0;
      end

      // host writes land in the shadow copy only; channel index and commit are written directly
      if (cfg_wr) begin
         case (cfg_addr)
            ADDR_CHAN_INDEX: st_d.chsel = cfg_wdata & MSK_CHAN_INDEX;
            ADDR_CLK_COND:   st_d.shd.clk = cfg_wdata & MSK_CLK_COND;
            ADDR_CLK_DIV:    st_d.shd.div = cfg_wdata & MSK_CLK_DIV;
            ADDR_SELFTEST:   st_d.shd.builtin_selftest = cfg_wdata & MSK_SELFTEST;
            ADDR_INPUT_BIAS: st_d.shd.inp = cfg_wdata & MSK_INPUT_BIAS;
            ADDR_COMMIT:     st_d.commit = cfg_wdata[POS_COMMIT];
            default: begin
               // local registers go to every selected channel
               for (int ch = 0; ch < 2; ch++) begin
                  if (st_q.chsel[ch]) begin
                     if (cfg_addr == ADDR_POWER_MODE) begin
                        st_d.shd.pwr[ch] = (cfg_wdata & MSK_POWER_MODE) | FIX_POWER_MODE;
                     end
                     if (cfg_addr == ADDR_TEST_PAT) begin
                        st_d.shd.tpat[ch] = cfg_wdata & MSK_TEST_PAT;
                     end
                     if (cfg_addr == ADDR_OFFSET) begin
                        st_d.shd.offs[ch] = cfg_wdata;
                     end
                  end
               end
            end
         endcase
      end

      // reads return the shadow; both selected reads channel A
      rd_b = !st_q.chsel[0] && st_q.chsel[1];
      case (cfg_addr)
         ADDR_CHAN_INDEX: rv = st_q.chsel;
         ADDR_POWER_MODE: rv = st_q.shd.pwr[rd_b];
         ADDR_CLK_COND:   rv = st_q.shd.clk;
         ADDR_CLK_DIV:    rv = st_q.shd.div;
         ADDR_TEST_PAT:   rv = st_q.shd.tpat[rd_b];
         ADDR_SELFTEST:   rv = st_q.shd.builtin_selftest;
         ADDR_INPUT_BIAS: rv = st_q.shd.inp;
         ADDR_OFFSET:     rv = st_q.shd.offs[rd_b];
         ADDR_COMMIT:     rv = {7'h00, st_q.commit};
         default:         rv = 8'h00; // unmapped reads as zero
      endcase
      if (cfg_rd) begin
         st_d.rdata = rv;
         st_d.rvld  = 1'b1;
      end

      // generators: held in seed while their reset bit is set
      for (int ch = 0; ch < 2; ch++) begin
         if (st_q.act.tpat[ch][POS_LONG_RST]) begin
            st_d.lgen[ch] = '1;
         end else if (smp_strobe) begin
            st_d.lgen[ch] = {st_q.lgen[ch][LONG_W-2:0],
                             st_q.lgen[ch][LONG_W-1] ^ st_q.lgen[ch][17]};
         end
         if (st_q.act.tpat[ch][POS_SHORT_RST]) begin
            st_d.sgen[ch] = '1;
         end else if (smp_strobe) begin
            st_d.sgen[ch] = {st_q.sgen[ch][SHORT_W-2:0],
                             st_q.sgen[ch][SHORT_W-1] ^ st_q.sgen[ch][4]};
         end
      end

      // output word per channel: pattern or trimmed sample
      if (smp_strobe) begin
         st_d.phase = !st_q.phase;
         st_d.dvld  = 1'b1;
         for (int ch = 0; ch < 2; ch++) begin
            case (acr_pattern_t'(st_q.act.tpat[ch][2:0]))
               TP_MIDSCALE: pat = '0;
               TP_POS_FS:   pat = POS_FS;
               TP_NEG_FS:   pat = NEG_FS;
               TP_CHECKER:  pat = st_q.phase ? ~CHECK : CHECK;
               TP_LONG_PN:  pat = SMP_W'(st_q.lgen[ch]);
               TP_SHORT_PN: pat = {{(SMP_W-SHORT_W){1'b0}}, st_q.sgen[ch]};
               TP_TOGGLE:   pat = {SMP_W{st_q.phase}};
               default:     pat = '0;
            endcase
            if (st_q.act.tpat[ch][2:0] != TP_OFF) begin
               st_d.dout[ch] = pat;
            end else begin
               st_d.dout[ch] = trim(smp_in[ch], st_q.act.offs[ch]);
            end
         end
      end

      // synchronous reset
      if (srst) begin
         st_d.shd    = cfg_reset();
         st_d.act    = cfg_reset();
         st_d.chsel  = RST_CHAN_INDEX;
         st_d.commit = 1'b0;
         st_d.lgen   = '1;
         st_d.sgen   = '1;
         st_d.phase  = 1'b0;
         st_d.dout   = '0;
         st_d.dvld   = 1'b0;
         st_d.rdata  = 8'h00;
         st_d.rvld   = 1'b0;
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   // decoded controls from the active copy
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         full_pd[ch] = (st_q.act.pwr[ch][1:0] == PWR_FULL_DOWN) ||
                       (pdwn_pin && !st_q.act.pwr[ch][POS_EXT_PD_FN]);
         standby[ch] = !full_pd[ch] &&
                       ((st_q.act.pwr[ch][1:0] == PWR_STANDBY) ||
                        (pdwn_pin && st_q.act.pwr[ch][POS_EXT_PD_FN]));
      end
   end

   assign div_ratio    = st_q.act.div[2:0];
   assign dcs_active   = st_q.act.clk[POS_DCS_EN] || (div_ratio != 3'b000);
   assign builtin_selftest_en      = st_q.act.builtin_selftest[POS_BUILTIN_SELFTEST_EN];
   assign builtin_selftest_seq_rst = st_q.act.builtin_selftest[POS_BUILTIN_SELFTEST_RST];
   assign cm_servo_en  = st_q.act.inp[POS_SERVO_EN];
   assign smp_out      = st_q.dout;
   assign smp_out_vld  = st_q.dvld;
   assign cfg_rdata    = st_q.rdata;
   assign cfg_rvalid   = st_q.rvld;
endmodule

// [test/acr_regbank_asserts.sv]
/* checker: port timing and control decode of the control register bank
   assumes: bound to each acr_regbank, one clock, sync reset */
`timescale 1ns/100ps
module acr_regbank_asserts #(
   parameter int SMP_W = 14 // sample width
) (
   input wire logic                  core_clk,
   input wire logic                  srst,
   input wire logic                  cfg_wr,
   input wire logic                  cfg_rd,
   input wire logic [7:0]            cfg_addr,
   input wire logic [7:0]            cfg_wdata,
   input wire logic [7:0]            cfg_rdata,
   input wire logic                  cfg_rvalid,
   input wire logic                  pdwn_pin,
   input wire logic                  smp_strobe,
   input wire logic [1:0][SMP_W-1:0] smp_in,
   input wire logic [1:0][SMP_W-1:0] smp_out,
   input wire logic                  smp_out_vld,
   input wire logic [1:0]            full_pd,
   input wire logic [1:0]            standby,
   input wire logic                  dcs_active,
   input wire logic [2:0]            div_ratio,
   input wire logic                  builtin_selftest_en,
   input wire logic                  builtin_selftest_seq_rst,
   input wire logic                  cm_servo_en
);
   default clocking dck @(posedge core_clk);
   endclocking
   default disable iff (srst);
   AST_RD_ANS: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read strobe not answered");
   AST_UNMAPPED: assert property (cfg_rd && !(cfg_addr inside {8'h05, 8'h08, 8'h09,
      8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'hff}) |=> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_CLK_OPEN: assert property (cfg_rd && cfg_addr == 8'h09 |=> cfg_rdata[7:1] == 7'h00)
      else $error("open clock bits read set");
   AST_PWR_EXCL: assert property ((full_pd & standby) == 2'b00)
      else $error("standby with power-down");
   AST_PIN: assert property (pdwn_pin |-> (full_pd | standby) == 2'b11)
      else $error("power pin without effect");
   AST_DCS: assert property (div_ratio != 3'h0 |-> dcs_active)
      else $error("stabilizer off while dividing");
   AST_GLOBAL_HOLD: assert property (!$stable({div_ratio, builtin_selftest_en, builtin_selftest_seq_rst, cm_servo_en})
      |-> $past(cfg_wr && cfg_addr == 8'hff && cfg_wdata[0], 2) || $past(srst))
      else $error("global control changed without commit");
   AST_SMP_VLD: assert property (smp_strobe |=> smp_out_vld)
      else $error("sample strobe not answered");
   AST_SMP_HOLD: assert property (!smp_strobe |=> !smp_out_vld && $stable(smp_out))
      else $error("output word moved without strobe");
endmodule
bind acr_regbank acr_regbank_asserts #(.SMP_W(SMP_W)) i_chk (.*);

// [test/acr_host_model.sv]
/* host model: serial port engine issuing register strobes
   assumes: bench calls wr and rd; signals change at falling edge */
`timescale 1ns/100ps
module acr_host_model (
   input  wire logic       core_clk,
   output logic            cfg_wr,
   output logic            cfg_rd,
   output logic [7:0]      cfg_addr,
   output logic [7:0]      cfg_wdata,
   input  wire logic [7:0] cfg_rdata,
   input  wire logic       cfg_rvalid
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   // one write pulse; released lines show inverted last value
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~d;
   endtask
   // one read pulse; answer taken one cycle on
   task rd(input logic [7:0] a, output logic [8:0] d);
      @(negedge core_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      cfg_addr = ~a;
      d = {cfg_rvalid, cfg_rdata};
   endtask
endmodule

// [test/acr_regbank_bench.sv]
/* bench: register map, commit, power, divider and pattern checks
   assumes: host model drives the register strobes */
`timescale 1ns/100ps
module acr_regbank_bench;
   import acr_pkg::*;
   typedef struct packed {logic [7:0] a, w, r, e;} acr_row_t;
   // address, write, reset read, read after write
   acr_row_t rows [9] = '{'{8'h05, 8'hfd, 8'h03, 8'h01}, '{8'h08, 8'hff, 8'h80, 8'ha3},
      '{8'h09, 8'hfe, 8'h01, 8'h00}, '{8'h0b, 8'hff, 8'h00, 8'h07},
      '{8'h0d, 8'hff, 8'h00, 8'h37}, '{8'h0e, 8'hfa, 8'h04, 8'h00},
      '{8'h0f, 8'hff, 8'h00, 8'h01}, '{8'h10, 8'h81, 8'h00, 8'h81},
      '{8'h20, 8'hff, 8'h00, 8'h00}};
   logic [13:0] pat [8] = '{14'h0, 14'h0, 14'h1fff, 14'h2000, 14'h0, 14'h3fff, 14'h01ff, 14'h0};
   logic core_clk = 1'b0, srst = 1'b1, pdwn_pin = 1'b0, smp_strobe = 1'b0;
   logic cfg_wr, cfg_rd, cfg_rvalid, smp_out_vld, dcs_active, builtin_selftest_en, builtin_selftest_seq_rst, cm_servo_en;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
   logic [1:0][13:0] smp_in = '0, smp_out, s1, s2;
   logic [1:0] full_pd, standby;
   logic [2:0] div_ratio;
   logic [8:0] rdv;
   logic fpd, sb;
   int miscompares = 0, num_checks = 0, cycles = 0;
   acr_regbank i_dut (.*);
   acr_host_model i_host (.*);
   always #5 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end
   task check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done();
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // commit then let the active copies land
   task commit();
      i_host.wr(ADDR_COMMIT, 8'h01);
      repeat (2) @(negedge core_clk);
   endtask
   // one strobe per call, output word kept in s
   task smp(input logic [13:0] a, input logic [13:0] b, output logic [1:0][13:0] s);
      @(negedge core_clk);
      smp_strobe = 1'b1;
      smp_in = {b, a};
      @(negedge core_clk);
      smp_strobe = 1'b0;
      s = smp_out;
      check(smp_out_vld, 1'b1);
   endtask
   initial begin
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      check({dcs_active, builtin_selftest_en, builtin_selftest_seq_rst, cm_servo_en, div_ratio}, 7'h50);
      foreach (rows[i]) begin
         i_host.rd(rows[i].a, rdv);
         check(rdv, {1'b1, rows[i].r});
         i_host.wr(rows[i].a, rows[i].w);
         i_host.rd(rows[i].a, rdv);
         check(rdv, {1'b1, rows[i].e});
      end
      check({dcs_active, builtin_selftest_seq_rst, cm_servo_en, div_ratio}, 6'h30);
      commit();
      check({dcs_active, builtin_selftest_seq_rst, cm_servo_en, div_ratio}, 6'h2f);
      i_host.rd(ADDR_COMMIT, rdv);
      check(rdv, 9'h100);
      // divider sweep with stabilizer enable cleared
      for (int k = 0; k < 8; k++) begin
         i_host.wr(ADDR_CLK_DIV, 8'(k));
         commit();
         check({dcs_active, div_ratio}, {k != 0, 3'(k)});
      end
      // power codes with pin, channel A selected only
      for (int i = 0; i < 8; i++) begin
         i_host.wr(ADDR_POWER_MODE, {2'b00, i[1], 3'b000, i[1:0]});
         pdwn_pin = i[2];
         commit();
         fpd = i[1:0] == 2'b01 || (i[2] && !i[1]);
         sb = !fpd && (i[1:0] == 2'b10 || (i[2] && i[1]));
         check({full_pd[1], full_pd[0], standby[0]}, {i[2], fpd, sb});
      end
      pdwn_pin = 1'b0;
      i_host.wr(ADDR_OFFSET, 8'hfe);
      i_host.wr(ADDR_CHAN_INDEX, 8'h02);
      i_host.wr(ADDR_OFFSET, 8'h05);
      i_host.wr(ADDR_CHAN_INDEX, 8'h03);
      i_host.rd(ADDR_OFFSET, rdv);
      check(rdv, 9'h1fe);
      i_host.wr(ADDR_TEST_PAT, 8'h00);
      commit();
      smp(14'h0005, 14'h1ffe, s1);
      check(s1, {14'h1fff, 14'h0003});
      // every nonzero pattern code, generators held at seed
      for (int c = 1; c < 8; c++) begin
         i_host.wr(ADDR_TEST_PAT, 8'h30 | 8'(c));
         commit();
         smp(14'h0005, 14'h0005, s1);
         smp(14'h0005, 14'h0005, s2);
         if (c == 4 || c == 7)
            check(s1 ^ s2, 28'hfffffff);
         else
            check({s1, s2}, {4{pat[c]}});
      end
      i_host.wr(ADDR_TEST_PAT, 8'h15);
      commit();
      smp(14'h0005, 14'h0005, s1);
      smp(14'h0005, 14'h0005, s2);
      check(s2[0] == 14'h3fff, 1'b0);
      // self-test enable and sequence reset both set
      i_host.wr(ADDR_SELFTEST, 8'h05);
      commit();
      check({builtin_selftest_en, builtin_selftest_seq_rst}, 2'b11);
      // mid-run reset brings the reset image back
      srst = 1'b1;
      @(negedge core_clk);
      srst = 1'b0;
      check({dcs_active, builtin_selftest_en, builtin_selftest_seq_rst, cm_servo_en, div_ratio}, 7'h50);
      i_host.rd(ADDR_CHAN_INDEX, rdv);
      check(rdv, 9'h103);
      test_done();
   end
endmodule
